// ===== hw/host_bus_strobe_wait_port.sv
// Purpose: Strobe decode and wait/acknowledge handshake of the host port.
// Assumes: Straps are static; host strobes asynchronous to i_clk_sys.
// Notes:   Data pins are split into in, out and enable signals.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Generic style: write line is low-active strobe; data captured at its rising edge.
// - Enable-clock style: write pin is direction, high reads, low writes.
// - Strobe-ack style: write pin is direction, high reads, low writes.
// - Device answers bus cycles only while chip select is low.
// - Generic style: wait driven low during a transfer.
// - Generic style: wait driven high on completion, then released.
// - Strobe-ack style: acknowledge driven high during a transfer.
// - Strobe-ack style: acknowledge driven inactive on completion, then released.
// - Indirect mode: host may use wait as readiness handshake.
// - Generic style: read line low-active; data drivers on only while low.
// - Enable-clock style: read pin is enable; transfer when it goes high.
// - Indirect mode: address bit zero with strobes selects kind of data.
module host_bus_strobe_wait_port (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_n,
    input  wire logic [1:0]           i_bus_style_straps,
    input  wire logic                 i_addressing_mode_strap,
    input  wire logic                 i_chip_select_n,
    input  wire logic                 i_write_n,
    input  wire logic                 i_read_n,
    input  wire logic                 i_address_bit_zero,
    input  wire logic [7:0]           i_data,
    input  wire logic [7:0]           i_read_data,
    output logic [7:0]                o_data,
    output logic                      o_data_oe,
    output logic                      o_wait_out,
    output logic                      o_wait_oe,
    output host_port_pkg::access_req_t o_req,
    output logic                      o_req_valid,
    output logic                      o_indirect_mode
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {IDLE, ACCESS, DONE, RELEASE} port_state_t;

    port_state_t                  state_q;
    host_port_pkg::host_strobes_t sync_s;
    host_port_pkg::host_strobes_t prev_q;
    logic [1:0]                   style_q;
    logic                         indirect_q;
    logic                         straps_taken_q;
    logic [host_port_pkg::CNT_W-1:0] cnt_q;
    logic                         is_write_q;
    logic [7:0]                   data_q;
    logic                         addr_q;
    logic                         start;
    logic                         start_write;
    logic                         active_end;
    logic                         selected;

    // Handshake pin active level for the present style
    function automatic logic hs_active(input logic [1:0] style);
        hs_active = (style == host_port_pkg::STYLE_STROBE_ACK);
    endfunction : hs_active

    // ----------------------------------------------------------------
    // Synchronise the host strobes
    // ----------------------------------------------------------------
    strobe_sync u_sync (
        .i_clk_sys         (i_clk_sys),
        .i_rst_n           (i_rst_n),
        .i_async           ({i_chip_select_n, i_write_n, i_read_n}),
        .o_sync            (sync_s)
    );

    // Straps caught once after reset release, then held static
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            style_q        <= host_port_pkg::STYLE_GENERIC;
            indirect_q     <= 1'b0;
            straps_taken_q <= 1'b0;
        end else if (!straps_taken_q) begin
            style_q        <= i_bus_style_straps;
            indirect_q     <= i_addressing_mode_strap;
            straps_taken_q <= 1'b1;
        end
    end

    // Previous synchronised strobes for edge detection
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_q <= 3'h7;
        end else begin
            prev_q <= sync_s;
        end
    end

    // ----------------------------------------------------------------
    // Start and end of a host cycle, per style
    // ----------------------------------------------------------------
    assign selected = !sync_s.chip_select_n;

    always_comb begin
        start       = 1'b0;
        start_write = 1'b0;
        active_end  = 1'b0;
        unique case (style_q)
            host_port_pkg::STYLE_GENERIC: begin
                // Write completes on the strobe's rising edge; read starts on fall
                start       = selected && ((!prev_q.write_n && sync_s.write_n)
                                           || (prev_q.read_n && !sync_s.read_n));
                start_write = !prev_q.write_n && sync_s.write_n;
                active_end  = sync_s.read_n;
            end
            host_port_pkg::STYLE_ENABLE_CLK: begin
                start       = selected && !prev_q.read_n && sync_s.read_n;
                start_write = !sync_s.write_n;
                active_end  = !sync_s.read_n;
            end
            host_port_pkg::STYLE_STROBE_ACK: begin
                start       = selected && prev_q.read_n && !sync_s.read_n;
                start_write = !sync_s.write_n;
                active_end  = sync_s.read_n;
            end
            default: begin
                start       = 1'b0;
                start_write = 1'b0;
                active_end  = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Transfer sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= IDLE;
            cnt_q   <= host_port_pkg::CNT_ZERO;
        end else begin
            unique case (state_q)
                IDLE: begin
                    if (start && straps_taken_q) begin
                        state_q <= ACCESS;
                        cnt_q   <= host_port_pkg::ACCESS_CNT;
                    end
                end
                ACCESS: begin
                    // Wait holds until the internal access count runs out
                    if (cnt_q <= 4'h1) begin
                        state_q <= DONE;
                        cnt_q   <= host_port_pkg::RELEASE_CNT;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                DONE: begin
                    if (cnt_q <= 4'h1) begin
                        state_q <= RELEASE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                RELEASE: begin
                    // Back to idle once host ends its strobe or drops select
                    if (active_end || sync_s.chip_select_n) begin
                        state_q <= IDLE;
                    end
                end
            endcase
        end
    end

    // Capture of write data, direction and data-kind bit
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            is_write_q <= 1'b0;
            data_q     <= host_port_pkg::DATA_ZERO;
            addr_q     <= 1'b0;
        end else if (state_q == IDLE && start && straps_taken_q) begin
            is_write_q <= start_write;
            data_q     <= i_data;
            addr_q     <= i_address_bit_zero;
        end
    end

    // Request to the internal core, one pulse per access
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_req_valid     <= 1'b0;
            o_req           <= '0;
            o_indirect_mode <= 1'b0;
        end else begin
            o_req_valid     <= (state_q == ACCESS) && (cnt_q == host_port_pkg::ACCESS_CNT);
            o_req           <= '{is_write: is_write_q, address_bit_zero: addr_q, data: data_q};
            o_indirect_mode <= indirect_q;
        end
    end

    // ----------------------------------------------------------------
    // Handshake pin: active during access, inactive, then floated
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wait_out <= 1'b1;
            o_wait_oe  <= 1'b0;
        end else if (style_q == host_port_pkg::STYLE_ENABLE_CLK
                     || style_q == host_port_pkg::STYLE_RESERVED) begin
            // Pin floats in this style; board leaves it open
            o_wait_out <= 1'b1;
            o_wait_oe  <= 1'b0;
        end else if (state_q == ACCESS || (state_q == IDLE && start && straps_taken_q)) begin
            o_wait_out <= hs_active(style_q) ? 1'b1 : 1'b0;
            o_wait_oe  <= 1'b1;
        end else if (state_q == DONE) begin
            o_wait_out <= ~hs_active(style_q);
            o_wait_oe  <= 1'b1;
        end else begin
            o_wait_out <= ~hs_active(style_q);
            o_wait_oe  <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read data drivers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data    <= host_port_pkg::DATA_ZERO;
            o_data_oe <= 1'b0;
        end else begin
            o_data <= i_read_data;
            unique case (style_q)
                host_port_pkg::STYLE_GENERIC:    o_data_oe <= selected && !sync_s.read_n;
                host_port_pkg::STYLE_ENABLE_CLK: o_data_oe <= selected && sync_s.write_n && sync_s.read_n;
                host_port_pkg::STYLE_STROBE_ACK: o_data_oe <= selected && sync_s.write_n && !sync_s.read_n;
                default:                         o_data_oe <= 1'b0;
            endcase
        end
    end

endmodule : host_bus_strobe_wait_port
`default_nettype wire

// ===== hw/host_port_pkg.sv
// Purpose: Shared types and constants for the host bus strobe and wait port.
// Assumes: One internal clock at 125 MHz; host strobes are asynchronous.
// Notes:   Bus style and addressing mode come from static straps.
package host_port_pkg;

    // ----------------------------------------------------------------
    // Bus styles selected by the two style straps
    // ----------------------------------------------------------------
    localparam logic [1:0] STYLE_GENERIC     = 2'h0;
    localparam logic [1:0] STYLE_STROBE_ACK  = 2'h1;
    localparam logic [1:0] STYLE_ENABLE_CLK  = 2'h2;
    localparam logic [1:0] STYLE_RESERVED    = 2'h3;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 8;
    // Least time the internal access takes once a strobe is seen
    localparam int ACCESS_TIME_NS  = 40;
    localparam int ACCESS_CYCLES   = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Time the inactive level is driven before the handshake pin floats
    localparam int RELEASE_TIME_NS = 8;
    localparam int RELEASE_CYCLES  = (RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W           = 4;
    localparam logic [CNT_W-1:0] ACCESS_CNT  = CNT_W'(ACCESS_CYCLES);
    localparam logic [CNT_W-1:0] RELEASE_CNT = CNT_W'(RELEASE_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;

    // Synchroniser depth
    localparam int SYNC_STAGES = 2;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic chip_select_n;
        logic write_n;
        logic read_n;
    } host_strobes_t;

    typedef struct packed {
        logic       is_write;
        logic       address_bit_zero;
        logic [7:0] data;
    } access_req_t;

    localparam logic [7:0] DATA_ZERO = 8'h00;

endpackage : host_port_pkg

// ===== hw/strobe_sync.sv
// Purpose: Two-stage synchroniser for the asynchronous host strobe bundle.
// Assumes: Reset values match idle (inactive) host strobes of the generic and strobe-ack styles.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none
module strobe_sync (
    input  wire logic                         i_clk_sys,
    input  wire logic                         i_rst_n,
    input  wire host_port_pkg::host_strobes_t i_async,
    output host_port_pkg::host_strobes_t      o_sync
);
    host_port_pkg::host_strobes_t meta_q;
    host_port_pkg::host_strobes_t sync_q;

    // ----------------------------------------------------------------
    // Chain; idle value for read line depends on style, so both
    // stages reset to generic idle and settle within two cycles
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 3'h7;
            sync_q <= 3'h7;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : strobe_sync
`default_nettype wire

// ===== sim/host_bus_master_model.sv
// Purpose: Host processor with address decoder driving the port strobes.
// Assumes: Called from the bench; all changes land just after a rising edge.
// Notes:   A released data bus shows the inverse of the last value.
`timescale 1ns/1ns
`default_nettype none
module host_bus_master_model (
    input  wire logic  i_clk_sys,
    input  wire logic  i_wait_out,
    input  wire logic  i_wait_oe,
    output logic       o_chip_select_n,
    output logic       o_write_n,
    output logic       o_read_n,
    output logic       o_address_bit_zero,
    output logic [7:0] o_data
);
    // Idle bus until the first transfer
    initial begin
        o_chip_select_n = 1'b1;
        o_write_n = 1'b1;
        o_read_n = 1'b1;
        o_address_bit_zero = 1'b0;
        o_data = 8'h00;
    end
    // Enable of the enable-clock style rests low, strobes of the others high
    task automatic set_idle(input logic [1:0] s);
        o_read_n <= (s != host_port_pkg::STYLE_ENABLE_CLK);
    endtask : set_idle
    task automatic xfer(input logic [1:0] s, input logic wr, input logic a0, input logic [7:0] d,
                        input logic cs_n);
        @(posedge i_clk_sys);
        o_chip_select_n <= cs_n;
        o_address_bit_zero <= a0;
        o_data <= d;
        o_write_n <= ~wr;
        @(posedge i_clk_sys);
        if (s == host_port_pkg::STYLE_ENABLE_CLK) o_read_n <= 1'b1;
        else if (s != host_port_pkg::STYLE_GENERIC || !wr) o_read_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        if (s == host_port_pkg::STYLE_GENERIC) o_write_n <= 1'b1;
        // Data stays held through the handshake since capture lags the strobe
        if (s == host_port_pkg::STYLE_ENABLE_CLK) repeat (12) @(posedge i_clk_sys);
        else begin
            for (int n = 0; n < 40 && i_wait_oe !== 1'b1; n++) @(posedge i_clk_sys);
            // A released pin never counts as the active level
            for (int n = 0; n < 40 && i_wait_oe === 1'b1
                 && i_wait_out === (s == host_port_pkg::STYLE_STROBE_ACK); n++)
                @(posedge i_clk_sys);
        end
        o_chip_select_n <= 1'b1;
        o_write_n <= 1'b1;
        set_idle(s);
        o_data <= ~d;
        repeat (6) @(posedge i_clk_sys);
    endtask : xfer
endmodule : host_bus_master_model
`default_nettype wire

// ===== sim/host_bus_strobe_wait_port_asserts.sv
// Purpose: Handshake pin, request pulse and data enable checks of the host port.
// Assumes: Straps change only while reset is held.
// Notes:   Active span may be five or six cycles, inactive level one cycle.
`timescale 1ns/1ns
`default_nettype none
module host_bus_strobe_wait_port_asserts (
    input wire logic                       i_clk_sys,
    input wire logic                       i_rst_n,
    input wire logic [1:0]                 i_bus_style_straps,
    input wire logic                       i_addressing_mode_strap,
    input wire logic                       i_chip_select_n,
    input wire logic                       i_write_n,
    input wire logic                       i_read_n,
    input wire logic                       i_address_bit_zero,
    input wire logic [7:0]                 i_data,
    input wire logic [7:0]                 i_read_data,
    input wire logic [7:0]                 o_data,
    input wire logic                       o_data_oe,
    input wire logic                       o_wait_out,
    input wire logic                       o_wait_oe,
    input wire host_port_pkg::access_req_t o_req,
    input wire logic                       o_req_valid,
    input wire logic                       o_indirect_mode
);
    logic gen;
    logic ack;
    // Style decode; straps are static outside reset
    assign gen = (i_bus_style_straps == host_port_pkg::STYLE_GENERIC);
    assign ack = (i_bus_style_straps == host_port_pkg::STYLE_STROBE_ACK);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    property p_enclk_float; i_bus_style_straps[1] |-> !o_wait_oe;
    endproperty
    a_enclk_float: assert property (p_enclk_float) else $error("handshake pin driven without handshake style");
    property p_gen_wait; gen && $rose(o_wait_oe) |-> (o_wait_oe && !o_wait_out)[*5]
        ##[1:2] (o_wait_oe && o_wait_out) ##1 !o_wait_oe; endproperty
    a_gen_wait: assert property (p_gen_wait) else $error("wait low span or release wrong");
    property p_ack_wait; ack && $rose(o_wait_oe) |-> (o_wait_oe && o_wait_out)[*5]
        ##[1:2] (o_wait_oe && !o_wait_out) ##1 !o_wait_oe; endproperty
    a_ack_wait: assert property (p_ack_wait) else $error("acknowledge span or release wrong");
    property p_req_follows; $rose(o_wait_oe) |=> o_req_valid;
    endproperty
    a_req_follows: assert property (p_req_follows) else $error("request not one cycle after wait");
    property p_req_single; o_req_valid |=> !o_req_valid;
    endproperty
    a_req_single: assert property (p_req_single) else $error("request pulse longer than one cycle");
    property p_cs_idle; i_chip_select_n[*8] |-> !o_req_valid && !o_wait_oe && !o_data_oe;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("activity without chip select");
    property p_rd_oe; gen && i_read_n[*6] |-> !o_data_oe;
    endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("data driven without read strobe");
    property p_mode_copy; $past(i_rst_n, 2) |-> o_indirect_mode == i_addressing_mode_strap;
    endproperty
    a_mode_copy: assert property (p_mode_copy) else $error("addressing mode copy wrong");
    c_gen_write: cover property (gen && o_req_valid && o_req.is_write);
    c_ack_read: cover property (ack && o_req_valid && !o_req.is_write);
    c_enclk_req: cover property (i_bus_style_straps == host_port_pkg::STYLE_ENABLE_CLK && o_req_valid);
endmodule : host_bus_strobe_wait_port_asserts

bind host_bus_strobe_wait_port host_bus_strobe_wait_port_asserts i_asserts (.i_clk_sys, .i_rst_n,
    .i_bus_style_straps, .i_addressing_mode_strap, .i_chip_select_n, .i_write_n, .i_read_n,
    .i_address_bit_zero, .i_data, .i_read_data, .o_data, .o_data_oe, .o_wait_out, .o_wait_oe, .o_req,
    .o_req_valid, .o_indirect_mode);
`default_nettype wire

// ===== sim/host_bus_strobe_wait_port_tb.sv
// Purpose: Self-checking bench over all bus styles, with chip select refusals.
// Assumes: Straps are changed only under reset.
// Notes:   Read notes skip the data field, which the host does not drive.
`timescale 1ns/1ns
`default_nettype none
module host_bus_strobe_wait_port_tb;
    logic        i_clk_sys = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [1:0]  i_bus_style_straps = 2'h0;
    logic        i_addressing_mode_strap = 1'b0;
    logic        i_chip_select_n, i_write_n, i_read_n, i_address_bit_zero;
    logic [7:0]  i_data, host_data, o_data, i_read_data = 8'h00;
    logic        o_data_oe, o_wait_out, o_wait_oe, o_req_valid, o_indirect_mode;
    host_port_pkg::access_req_t o_req;
    logic [10:0] notes[$];
    int          miscompares = 0;
    int          comparisons = 0;
    always #4 i_clk_sys = ~i_clk_sys;
    // Data wire: the device wins only while its driver is enabled
    assign i_data = o_data_oe ? o_data : host_data;
    host_bus_master_model i_host (.i_clk_sys, .i_wait_out(o_wait_out), .i_wait_oe(o_wait_oe),
        .o_chip_select_n(i_chip_select_n), .o_write_n(i_write_n), .o_read_n(i_read_n),
        .o_address_bit_zero(i_address_bit_zero), .o_data(host_data));
    host_bus_strobe_wait_port i_dut (.i_clk_sys, .i_rst_n, .i_bus_style_straps, .i_addressing_mode_strap,
        .i_chip_select_n, .i_write_n, .i_read_n, .i_address_bit_zero, .i_data, .i_read_data, .o_data,
        .o_data_oe, .o_wait_out, .o_wait_oe, .o_req, .o_req_valid, .o_indirect_mode);
    task automatic cmp_val(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : cmp_val
    task automatic cmp_req(input logic [10:0] n, input host_port_pkg::access_req_t got);
        comparisons++;
        if (n[9:8] !== {got.is_write, got.address_bit_zero} || (n[10] && n[7:0] !== got.data)) begin
            miscompares++;
            $display("unexpected request: expected %h seen %h", n[9:0], got);
        end
    endtask : cmp_req
    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic do_reset(input logic [1:0] s);
        i_rst_n <= 1'b0;
        i_bus_style_straps <= s;
        // Odd styles run indirect, so both addressing modes are seen
        i_addressing_mode_strap <= s[0];
        i_host.set_idle(s);
        repeat (20) @(posedge i_clk_sys);
        cmp_val("reset outputs", 8'h04, {4'h0, o_wait_oe, o_wait_out, o_data_oe, o_req_valid});
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        cmp_val("indirect mode", {7'h00, i_addressing_mode_strap}, {7'h00, o_indirect_mode});
    endtask : do_reset
    // Driver notes the request first so the watcher always finds it queued
    task automatic run(input logic [1:0] s, input logic wr, input logic a0, input logic [7:0] d,
                       input logic cs_n);
        @(posedge i_clk_sys);
        i_read_data <= 8'($urandom);
        if (!cs_n && s != host_port_pkg::STYLE_RESERVED) notes.push_back({wr, wr, a0, d});
        i_host.xfer(s, wr, a0, d, cs_n);
    endtask : run
    // Watcher: oldest note against each request pulse, read data while driven
    logic [10:0] head;
    always @(posedge i_clk_sys) begin
        if (i_rst_n && o_req_valid === 1'b1) begin
            if (notes.size() == 0) cmp_val("spurious request", 8'h00, 8'h01);
            else begin
                head = notes.pop_front();
                cmp_req(head, o_req);
                // Reads still hold their strobe here, writes never enable the drivers
                cmp_val("data enable", {7'h00, ~head[9]}, {7'h00, o_data_oe});
            end
        end
        if (i_rst_n && o_data_oe === 1'b1) cmp_val("read data", i_read_data, o_data);
    end
    // Every style, reserved one too; the last transfer of each lacks chip select
    initial begin
        void'($urandom(25));
        @(posedge i_clk_sys);
        for (int s = 0; s < 4; s++) begin
            do_reset(2'(s));
            for (int k = 0; k < 8; k++) run(2'(s), 1'($urandom), 1'($urandom), 8'($urandom), k == 7);
        end
        cmp_val("notes left", 8'h00, 8'(notes.size()));
        end_of_test();
    end
    // Watchdog: the whole run needs only about a thousand cycles
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        miscompares++;
        end_of_test();
    end
endmodule : host_bus_strobe_wait_port_tb
`default_nettype wire
